// file: hw/ch_postproc.sv
// channel 16 gain and offset, high-pass and test patterns for channels 13 to 16 behind an axi4-lite slave
//
// Function
// - channel 16 gain is code times 0.2 dB
// - gain code used only with gain enable
// - 10-bit signed offset, only with offset enable
// - per-lane prbs bits, only with lane select
// - lanes 13/14 pattern codes, only with select
// - high-pass enable bit switches all four channels
// - filter output 2^k/(2^k+1) times difference sum
// - k matters only while high-pass enabled
// - gain/offset register sits at index 0x37
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "postproc_defines.svh"

module ch_postproc
    import postproc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // axi4-lite slave
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // sample stream, lane 13 in the low slice
    input  wire logic        sample_valid,
    input  wire logic [55:0] sample_in,
    output logic [55:0]      lane_out,
    output logic             lane_valid
);

    // ****************************************************
    // registers
    // ****************************************************
    logic [15:0] ctrl3_q;      // global gain/offset enables
    logic [15:0] ctrl4_q;      // per-lane pattern select
    logic [15:0] gainoff_q;    // channel 16 gain and offset
    logic [15:0] mirror_q;     // channel 16 offset mirror
    logic [15:0] pathpf_q;     // patterns and high-pass control

    // named fields
    logic        global_gain_enable;
    logic        global_offset_enable;
    logic        per_lane_pattern_select;
    logic [4:0]  ch16_gain_code;
    logic [9:0]  ch16_offset_value;
    logic [3:0]  group4_highpass_k;
    logic        group4_highpass_enable;
    pat_code_t   lane13_pattern_code;
    pat_code_t   lane14_pattern_code;

    assign global_gain_enable      = ctrl3_q[`BIT_GAIN_EN];
    assign global_offset_enable    = ctrl3_q[`BIT_OFFSET_EN];
    assign per_lane_pattern_select = ctrl4_q[`BIT_LANE_SEL];
    assign ch16_gain_code          = gainoff_q[`GAIN_MSB:`GAIN_LSB];
    // the mirror copy is storage only; software keeps both equal
    assign ch16_offset_value       = gainoff_q[`OFFSET_MSB:`OFFSET_LSB];
    assign group4_highpass_k       = pathpf_q[`HPF_K_MSB:`HPF_K_LSB];
    assign group4_highpass_enable  = pathpf_q[`HPF_EN_BIT];
    assign lane13_pattern_code     = pat_code_t'(pathpf_q[`PAT13_MSB:`PAT13_LSB]);
    assign lane14_pattern_code     = pat_code_t'(pathpf_q[`PAT14_MSB:`PAT14_LSB]);

    // ****************************************************
    // bus slave: write channel
    // ****************************************************
    logic        aw_hold_q;    // write address captured
    logic        w_hold_q;     // write data captured
    logic [9:0]  aw_idx_q;     // captured word index
    logic [15:0] wdata_q;      // captured low half of data
    logic [1:0]  wstrb_q;      // captured low byte enables
    logic        aw_take;
    logic        w_take;
    logic        wr_fire;
    logic        aw_hold_d;
    logic        w_hold_d;
    logic        wr_hit;

    assign aw_take   = s_awvalid && s_awready;
    assign w_take    = s_wvalid && s_wready;
    // the write lands only once the previous response is gone
    assign wr_fire   = aw_hold_q && w_hold_q && !s_bvalid;
    assign aw_hold_d = (aw_hold_q || aw_take) && !wr_fire;
    assign w_hold_d  = (w_hold_q || w_take) && !wr_fire;
    assign wr_hit    = aw_idx_q == `IDX_GLOBAL_CTRL3 || aw_idx_q == `IDX_GLOBAL_CTRL4 ||
                       aw_idx_q == `IDX_CH16_GAINOFF || aw_idx_q == `IDX_CH16_MIRROR ||
                       aw_idx_q == `IDX_PATTERN_HPF;

    // byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] be);
        merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    // address and data hand-shakes, either order
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            aw_idx_q  <= 10'h0;
            wdata_q   <= 16'h0;
            wstrb_q   <= 2'h0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            s_awready <= !aw_hold_d;
            s_wready  <= !w_hold_d;
            if (aw_take) begin
                aw_idx_q <= s_awaddr[11:2];
            end
            if (w_take) begin
                wdata_q <= s_wdata[15:0];
                wstrb_q <= s_wstrb[1:0];
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_bvalid <= 1'b0;
            s_bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_bvalid <= 1'b1;
            s_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // register storage; reserved bits are kept as written
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl3_q   <= `REG_RESET;
            ctrl4_q   <= `REG_RESET;
            gainoff_q <= `REG_RESET;
            mirror_q  <= `REG_RESET;
            pathpf_q  <= `REG_RESET;
        end else if (wr_fire) begin
            case (aw_idx_q)
                `IDX_GLOBAL_CTRL3: ctrl3_q   <= merge(ctrl3_q, wdata_q, wstrb_q);
                `IDX_GLOBAL_CTRL4: ctrl4_q   <= merge(ctrl4_q, wdata_q, wstrb_q);
                `IDX_CH16_GAINOFF: gainoff_q <= merge(gainoff_q, wdata_q, wstrb_q);
                `IDX_CH16_MIRROR:  mirror_q  <= merge(mirror_q, wdata_q, wstrb_q);
                `IDX_PATTERN_HPF:  pathpf_q  <= merge(pathpf_q, wdata_q, wstrb_q);
                default: ;
            endcase
        end
    end

    // ****************************************************
    // bus slave: read channel
    // ****************************************************
    logic [9:0]  ar_idx;
    logic [15:0] rd_word;
    logic        rd_hit;
    logic        ar_take;
    logic        rvalid_d;

    assign ar_idx   = s_araddr[11:2];
    assign ar_take  = s_arvalid && s_arready;
    assign rvalid_d = (s_rvalid && !s_rready) || ar_take;
    assign rd_hit   = ar_idx == `IDX_GLOBAL_CTRL3 || ar_idx == `IDX_GLOBAL_CTRL4 ||
                      ar_idx == `IDX_CH16_GAINOFF || ar_idx == `IDX_CH16_MIRROR ||
                      ar_idx == `IDX_PATTERN_HPF;
    assign rd_word  = (ar_idx == `IDX_GLOBAL_CTRL3) ? ctrl3_q   :
                      (ar_idx == `IDX_GLOBAL_CTRL4) ? ctrl4_q   :
                      (ar_idx == `IDX_CH16_GAINOFF) ? gainoff_q :
                      (ar_idx == `IDX_CH16_MIRROR)  ? mirror_q  :
                      (ar_idx == `IDX_PATTERN_HPF)  ? pathpf_q  : 16'h0;

    // one read in flight; data captured with the address
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= `RESP_OKAY;
        end else begin
            s_arready <= !rvalid_d;
            s_rvalid  <= rvalid_d;
            if (ar_take) begin
                s_rdata <= {16'h0, rd_word};
                s_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // ****************************************************
    // gain table: round(4096 * 10^(code*0.01))
    // ****************************************************
    function automatic logic [15:0] gain_lut(input logic [4:0] c);
        case (c)
            5'h00: gain_lut = 16'h1000;  5'h01: gain_lut = 16'h105f;
            5'h02: gain_lut = 16'h10c1;  5'h03: gain_lut = 16'h1125;
            5'h04: gain_lut = 16'h118b;  5'h05: gain_lut = 16'h11f4;
            5'h06: gain_lut = 16'h125f;  5'h07: gain_lut = 16'h12cc;
            5'h08: gain_lut = 16'h133c;  5'h09: gain_lut = 16'h13af;
            5'h0a: gain_lut = 16'h1425;  5'h0b: gain_lut = 16'h149d;
            5'h0c: gain_lut = 16'h1518;  5'h0d: gain_lut = 16'h1595;
            5'h0e: gain_lut = 16'h1616;  5'h0f: gain_lut = 16'h169a;
            5'h10: gain_lut = 16'h1721;  5'h11: gain_lut = 16'h17aa;
            5'h12: gain_lut = 16'h1838;  5'h13: gain_lut = 16'h18c8;
            5'h14: gain_lut = 16'h195c;  5'h15: gain_lut = 16'h19f3;
            5'h16: gain_lut = 16'h1a8e;  5'h17: gain_lut = 16'h1b2c;
            5'h18: gain_lut = 16'h1bce;  5'h19: gain_lut = 16'h1c74;
            5'h1a: gain_lut = 16'h1d1d;  5'h1b: gain_lut = 16'h1dcb;
            5'h1c: gain_lut = 16'h1e7d;  5'h1d: gain_lut = 16'h1f33;
            5'h1e: gain_lut = 16'h1fed;  default: gain_lut = 16'h20ab;
        endcase
    endfunction

    // ****************************************************
    // channel 16 gain and offset
    // ****************************************************
    logic [3:0]         hpf_valid;   // per-channel filter strobe
    sample_t            hpf_y [4];   // filter outputs
    logic [15:0]        gain_mult;   // q4.12 multiplier
    logic signed [30:0] gain_prod;
    logic signed [31:0] go_sum;
    sample_t            ch16_go;     // after gain and offset

    // clear enable falls back to unity gain and zero offset
    assign gain_mult = global_gain_enable ? gain_lut(ch16_gain_code) : `GAIN_UNITY;
    assign gain_prod = hpf_y[3] * $signed({1'b0, gain_mult});
    assign go_sum    = 32'(gain_prod >>> `GAIN_FRAC) +
                       (global_offset_enable ? 32'(signed'(ch16_offset_value)) : 32'sh0);
    // clamp instead of wrap so large offsets do not fold over
    assign ch16_go   = (go_sum > 32'sh1fff)  ? sample_t'(`SAMPLE_MAX) :
                       (go_sum < -32'sh2000) ? sample_t'(`SAMPLE_MIN) : go_sum[13:0];

    // ****************************************************
    // pattern sources, shared by all lanes
    // ****************************************************
    logic [22:0] prbs_q;     // x^23 + x^18 + 1
    logic        toggle_q;   // alternating word select
    logic [13:0] ramp_q;     // ramp pattern counter

    // patterns advance once per sample
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prbs_q   <= `PRBS_SEED;
            toggle_q <= 1'b0;
            ramp_q   <= 14'h0;
        end else if (hpf_valid[0]) begin
            prbs_q   <= {prbs_q[21:0], prbs_q[22] ^ prbs_q[17]};
            toggle_q <= !toggle_q;
            ramp_q   <= ramp_q + 14'h1;
        end
    end

    // ****************************************************
    // per-channel filter and lane selection
    // ****************************************************
    logic [55:0] lane_d;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_lane
            sample_t   data_i;   // filtered, gain/offset on ch16
            pat_code_t code_i;   // pattern code for this lane
            sample_t   pat_i;    // coded pattern word

            hpf_stage u_hpf (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .en      (group4_highpass_enable),
                .k       (group4_highpass_k),
                .valid   (sample_valid),
                .x       (sample_in[i*14 +: 14]),
                .y       (hpf_y[i]),
                .y_valid (hpf_valid[i])
            );

            assign data_i = (i == 3) ? ch16_go : hpf_y[i];
            // only lanes 13 and 14 carry a code in this block
            assign code_i = (i == 0) ? lane13_pattern_code :
                            (i == 1) ? lane14_pattern_code : PAT_NORMAL;
            assign pat_i  = (code_i == PAT_ZEROS)  ? 14'h0000 :
                            (code_i == PAT_ONES)   ? 14'h3fff :
                            (code_i == PAT_TOGGLE) ? (toggle_q ? 14'h2aaa : 14'h1555) :
                            (code_i == PAT_RAMP)   ? ramp_q : data_i;
            // prbs outranks the code; both need lane select
            assign lane_d[i*14 +: 14] =
                !per_lane_pattern_select         ? data_i :
                pathpf_q[`PRBS_TOP_BIT - i]      ? prbs_q[13:0] :
                pat_i;
        end
    endgenerate

    // output lanes, one cycle after the filter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lane_out   <= 56'h0;
            lane_valid <= 1'b0;
        end else begin
            lane_valid <= hpf_valid[0];
            if (hpf_valid[0]) begin
                lane_out <= lane_d;
            end
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_unity_pass: assert property (
        (hpf_valid[3] && !global_gain_enable && !global_offset_enable &&
         !per_lane_pattern_select) |=> (lane_out[55:42] == $past(hpf_y[3])))
        else $error("channel 16 not passed at unity");

    chk_gain_code0: assert property (
        (hpf_valid[3] && global_gain_enable && ch16_gain_code == 5'h00 &&
         !global_offset_enable && !per_lane_pattern_select)
        |=> (lane_out[55:42] == $past(hpf_y[3])))
        else $error("zero gain code changed the sample");

    chk_gain_rises: assert property (
        (global_gain_enable && ch16_gain_code == 5'h1f) |-> (gain_mult == 16'h20ab))
        else $error("top gain code not 6.2 dB");

    chk_offset_add: assert property (
        (hpf_valid[3] && !global_gain_enable && global_offset_enable &&
         !per_lane_pattern_select && hpf_y[3] < 14'sh0f00 && hpf_y[3] > -14'sh0f00)
        |=> ($signed(lane_out[55:42]) ==
             sample_t'($past(hpf_y[3]) + $past(signed'(ch16_offset_value)))))
        else $error("offset not added to channel 16");

    chk_prbs_lane: assert property (
        (hpf_valid[1] && per_lane_pattern_select && pathpf_q[14])
        |=> (lane_out[27:14] == $past(prbs_q[13:0])))
        else $error("lane 14 prbs not selected");

    chk_prbs_gated: assert property (
        (hpf_valid[0] && !per_lane_pattern_select) |=> (lane_out[13:0] == $past(hpf_y[0])))
        else $error("lane 13 pattern active without lane select");

    chk_pat_zeros: assert property (
        (hpf_valid[0] && per_lane_pattern_select && !pathpf_q[15] &&
         lane13_pattern_code == PAT_ZEROS) |=> (lane_out[13:0] == 14'h0) ##1 1'b1)
        else $error("lane 13 zero pattern not driven");

    chk_read_gainoff: assert property (
        (ar_take && ar_idx == `IDX_CH16_GAINOFF)
        |=> s_rvalid && (s_rdata == {16'h0, $past(gainoff_q)}))
        else $error("gain/offset register not at its index");

endmodule

// file: hw/hpf_stage.sv
// first-order digital high-pass stage for one channel
`timescale 1ns/1ps
`include "postproc_defines.svh"

module hpf_stage
    import postproc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        en,
    input  wire logic [3:0]  k,
    input  wire logic        valid,
    input  wire sample_t     x,
    output sample_t          y,
    output logic             y_valid
);

    // ****************************************************
    // filter arithmetic
    // ****************************************************
    logic signed [25:0] x_full;   // input with fraction bits
    logic signed [25:0] xp_q;     // previous input
    logic signed [25:0] yp_q;     // previous output, full precision
    logic signed [25:0] sum;      // x(n) - x(n-1) + y(n-1)
    logic signed [25:0] y_d;      // scaled by 2^k/(2^k+1)
    logic signed [17:0] y_int;    // integer part before clamp
    logic        [4:0]  k2;       // second series shift
    sample_t            y_sat;    // clamped output

    assign x_full = {{4{x[13]}}, x, 8'h00};
    assign sum    = x_full - xp_q + yp_q;
    assign k2     = {k, 1'b0};
    // series 1 - 2^-k + 2^-2k; the remaining error stays below 2^-3k
    assign y_d    = sum - (sum >>> k) + (sum >>> k2);
    assign y_int  = y_d[25:`HPF_FRAC];
    assign y_sat  = (y_int > 18'sh01fff)  ? sample_t'(`SAMPLE_MAX) :
                    (y_int < -18'sh02000) ? sample_t'(`SAMPLE_MIN) : y_int[13:0];

    // ****************************************************
    // state and output registers
    // ****************************************************
    // when disabled the sample passes unchanged and k has no effect
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xp_q    <= 26'sh0;
            yp_q    <= 26'sh0;
            y       <= 14'sh0;
            y_valid <= 1'b0;
        end else begin
            y_valid <= valid;
            if (valid && en) begin
                xp_q <= x_full;
                yp_q <= y_d;
                y    <= y_sat;
            end else if (valid) begin
                // history cleared so enabling starts from rest
                xp_q <= 26'sh0;
                yp_q <= 26'sh0;
                y    <= x;
            end
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    chk_hpf_bypass: assert property (@(posedge mclk) disable iff (!rst_n)
        (valid && !en) |=> (y == $past(x)) && y_valid)
        else $error("disabled filter did not pass the sample");

    chk_hpf_settle: assert property (@(posedge mclk) disable iff (!rst_n)
        (valid && en && x_full == xp_q && yp_q == 26'sh0) |=> (y == 14'sh0))
        else $error("steady input from rest did not give zero output");

endmodule

// file: hw/postproc_defines.svh
// offsets, field positions, reset values and constants of the sample post-processing block
`ifndef POSTPROC_DEFINES_SVH
`define POSTPROC_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_GLOBAL_CTRL3   10'h003
`define IDX_GLOBAL_CTRL4   10'h004
`define IDX_CH16_GAINOFF   10'h037
`define IDX_CH16_MIRROR    10'h038
`define IDX_PATTERN_HPF    10'h039

// reset value of every register
`define REG_RESET          16'h0000

// field positions in the global control registers
`define BIT_GAIN_EN        12
`define BIT_OFFSET_EN      8
`define BIT_LANE_SEL       8

// field positions in the channel 16 gain/offset register
`define GAIN_MSB           15
`define GAIN_LSB           11
`define OFFSET_MSB         9
`define OFFSET_LSB         0

// field positions in the pattern/filter register
`define PRBS_TOP_BIT       15
`define PAT13_MSB          11
`define PAT13_LSB          9
`define PAT14_MSB          8
`define PAT14_LSB          6
`define HPF_K_MSB          4
`define HPF_K_LSB          1
`define HPF_EN_BIT         0

// datapath constants
`define GAIN_FRAC          12
`define GAIN_UNITY         16'h1000
`define HPF_FRAC           8
`define PRBS_SEED          23'h7fffff
`define SAMPLE_MAX         14'h1fff
`define SAMPLE_MIN         14'h2000

// bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// file: hw/postproc_pkg.sv
// types shared by the sample post-processing block
package postproc_pkg;

    // one signed adc sample
    typedef logic signed [13:0] sample_t;

    // per-lane test pattern codes
    typedef enum logic [2:0] {
        PAT_NORMAL = 3'b000,
        PAT_ZEROS  = 3'b001,
        PAT_ONES   = 3'b010,
        PAT_TOGGLE = 3'b011,
        PAT_RAMP   = 3'b100
    } pat_code_t;

endpackage

// file: test/lane_rx.sv
// receiver model that captures each processed lane set
`timescale 1ns/1ps

module lane_rx (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [55:0] lane_out,
    input  wire logic        lane_valid,
    output logic [55:0]      cap_q,
    output logic [31:0]      cnt_q
);
    // capture on the strobe only; lanes between strobes are not trusted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q <= 56'h0;
            cnt_q <= 32'h0;
        end else if (lane_valid) begin
            cap_q <= lane_out;
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule

// file: test/tb.sv
// self-checking bench for the channel post-processing block
`timescale 1ns/1ps

module tb;
    logic mclk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, sample_valid;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, lane_valid;
    logic [11:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, cnt_q;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, r;
    logic [55:0] sample_in, lane_out, cap_q;
    logic [15:0] d;
    int          fails, n_compared, i;
    typedef struct { logic [11:0] a; logic [15:0] w; logic [15:0] e; logic [1:0] r; } row_t;
    // ch16 1000, ch15 77, ch14 -500, ch13 1000
    localparam logic [55:0] X = {14'h03e8, 14'h004d, 14'h3e0c, 14'h03e8};
    row_t rows [4] = '{'{12'h0dc, 16'hf9ff, 16'hf9ff, 2'h0}, '{12'h0e0, 16'h03ff, 16'h03ff, 2'h0},
                       '{12'h0e4, 16'hffd5, 16'hffd5, 2'h0}, '{12'h0f0, 16'h1234, 16'h0, 2'h2}};

    ch_postproc i_dut (.*);
    lane_rx i_rx (.mclk(mclk), .rst_n(rst_n), .lane_out(lane_out), .lane_valid(lane_valid),
                  .cap_q(cap_q), .cnt_q(cnt_q));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask

    // a wait that runs out ends the run
    task automatic hang(input int n);
        if (n >= 50) begin
            fails++;
            $display("ERROR timeout");
            finish_test();
        end
    endtask

    // bvalid is tested first so no signal is assigned twice at the final edge
    // bready stays high between writes, so it is never lowered and raised in one step
    task automatic wr(input logic [11:0] a, input logic [15:0] w, output logic [1:0] rs);
        int n;
        s_awaddr <= a;
        s_wdata <= {16'h0, w};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_bvalid) break;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end
        hang(n);
        rs = s_bresp;
    endtask

    task automatic rd(input logic [11:0] a, output logic [15:0] v, output logic [1:0] rs);
        int n;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_rvalid) break;
            if (s_arready) s_arvalid <= 1'b0;
        end
        hang(n);
        v = s_rdata[15:0];
        rs = s_rresp;
    endtask

    // one strobe, then wait for the receiver to capture the result
    task automatic smp(input logic [55:0] x);
        int n;
        logic [31:0] c0;
        c0 = cnt_q;
        sample_in <= x;
        sample_valid <= 1'b1;
        @(posedge mclk);
        sample_valid <= 1'b0;
        for (n = 0; n < 50 && cnt_q === c0; n++) @(posedge mclk);
        hang(n);
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        {rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, sample_valid} = 7'h0;
        {s_awaddr, s_araddr, s_wdata, sample_in} = 112'h0;
        s_wstrb = 4'hf;
        fails = 0;
        n_compared = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        for (i = 0; i < 3; i++) begin
            rd(rows[i].a, d, r);
            chk("reset value", 56'h0, d);
        end
        for (i = 0; i < 4; i++) begin
            wr(rows[i].a, rows[i].w, r);
            chk("bresp", rows[i].r, r);
            rd(rows[i].a, d, r);
            chk("readback", rows[i].e, d);
            chk("rresp", rows[i].r, r);
        end
        $display("test registers done");
        wr(12'h0e4, 16'h0, r);
        wr(12'h0dc, 16'h83ff, r);
        wr(12'h0e0, 16'h03ff, r);
        wr(12'h00c, 16'h0, r);
        smp(X);
        chk("bypass", X, cap_q);
        wr(12'h00c, 16'h0100, r);
        smp(X);
        chk("offset", {14'h03e7, X[41:0]}, cap_q);
        wr(12'h00c, 16'h1000, r);
        smp(X);
        chk("gain", 56'h1, cap_q[55:42] > 14'h05a2 && cap_q[55:42] < 14'h05a8);
        wr(12'h00c, 16'h0, r);
        $display("test gain offset done");
        wr(12'h0e4, 16'h0280, r);
        wr(12'h010, 16'h0, r);
        smp(X);
        chk("pattern off", X, cap_q);
        wr(12'h010, 16'h0100, r);
        smp(X);
        chk("pattern", {X[55:28], 14'h3fff, 14'h0}, cap_q);
        wr(12'h0e4, 16'h1000, r);
        smp(X);
        chk("prbs other", X[41:0], cap_q[41:0]);
        chk("prbs16", 56'h3fe0, cap_q[55:42]);
        wr(12'h0e4, 16'h0700, r);
        smp(X);
        chk("toggle13", 56'h1555, cap_q[13:0]);
        chk("ramp14", 56'h6, cap_q[27:14]);
        wr(12'h0e4, 16'hc000, r);
        smp(X);
        chk("prbs13 14", {14'h3f80, 14'h3f80}, cap_q[27:0]);
        wr(12'h010, 16'h0, r);
        $display("test patterns done");
        wr(12'h0e4, 16'h0005, r);
        smp(X);
        chk("hpf first", 56'h1, cap_q[13:0] > 14'h0316 && cap_q[13:0] < 14'h0334);
        repeat (9) smp(X);
        chk("hpf decay", 56'h1, cap_q[13:0] < 14'h00fa);
        wr(12'h0e4, 16'h0004, r);
        smp(X);
        chk("hpf off", X, cap_q);
        $display("test highpass done");
        wr(12'h0dc, 16'hf800, r);
        wr(12'h0e0, 16'h0000, r);
        wr(12'h00c, 16'h1000, r);
        smp(X);
        chk("gain top", 56'h1, cap_q[55:42] > 14'h07f5 && cap_q[55:42] < 14'h07fd);
        wr(12'h0dc, 16'h0, r);
        smp(X);
        chk("gain zero code", X, cap_q);
        $display("test gain ends done");
        finish_test();
    end
endmodule
